// ---- twi_pkg.sv ----
// Package: register map, field positions, reset values and clock divisors of the two-wire controller.
package twi_pkg;

	// --------------------------------------------------------------------
	// Register byte offsets on the AHB-Lite bus.
	// --------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_OWN  = 8'h0C;
	localparam logic [7:0] OFS_PORT = 8'h10;

	// --------------------------------------------------------------------
	// Field positions.
	// --------------------------------------------------------------------
	localparam int CB_RATE2 = 7;
	localparam int CB_EN    = 6;
	localparam int CB_BEGIN = 5;
	localparam int CB_HALT  = 4;
	localparam int CB_ADDR  = 3;
	localparam int CB_ACK   = 2;
	localparam int CB_RATE1 = 1;
	localparam int CB_RATE0 = 0;
	localparam int OWN_GC   = 0;
	localparam int PB_SDA_BUS = 0;
	localparam int PB_SCL_BUS = 1;
	localparam int PB_SDA_OUT = 2;
	localparam int PB_SCL_OUT = 3;
	localparam int PB_SDA_DRV = 4;
	localparam int PB_SCL_DRV = 5;

	// --------------------------------------------------------------------
	// Reset values and line idle level.
	// --------------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OWN_RST  = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [9:0] CNT_RST  = 10'h000;
	localparam logic       LINE_IDLE = 1'b1;

	// --------------------------------------------------------------------
	// Serial clock divisors of the system clock, rate codes 0 to 7.
	// --------------------------------------------------------------------
	localparam int DIV_C0 = 16;
	localparam int DIV_C1 = 24;
	localparam int DIV_C2 = 30;
	localparam int DIV_C3 = 60;
	localparam int DIV_C4 = 120;
	localparam int DIV_C5 = 240;
	localparam int DIV_C6 = 480;
	localparam int DIV_C7 = 960;

	// Master clock sequencer states.
	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_START = 3'b001,
		M_LOW   = 3'b010,
		M_HIGH  = 3'b011,
		M_RS    = 3'b100,
		M_RS2   = 3'b101,
		M_STOP  = 3'b110,
		M_STOP2 = 3'b111
	} m_state_t;

	// Half a serial clock period in system cycles for a rate code.
	function automatic logic [9:0] half_of(input logic [2:0] code);
		case (code)
			3'h0: half_of = 10'(DIV_C0 / 2);
			3'h1: half_of = 10'(DIV_C1 / 2);
			3'h2: half_of = 10'(DIV_C2 / 2);
			3'h3: half_of = 10'(DIV_C3 / 2);
			3'h4: half_of = 10'(DIV_C4 / 2);
			3'h5: half_of = 10'(DIV_C5 / 2);
			3'h6: half_of = 10'(DIV_C6 / 2);
			default: half_of = 10'(DIV_C7 / 2);
		endcase
	endfunction : half_of

endpackage : twi_pkg

// ---- twi_line_if.sv ----
// Interface between the controller core, its line filter and its rate divider.
`timescale 1ns/100ps
interface twi_line_if;
	logic       sda_raw;
	logic       scl_raw;
	logic       sda_lvl;
	logic       scl_lvl;
	logic [2:0] rate;
	logic       clr;
	logic       tick;
	modport filt (input sda_raw, scl_raw, output sda_lvl, scl_lvl);
	modport div  (input rate, clr, output tick);
	modport core (output sda_raw, scl_raw, rate, clr, input sda_lvl, scl_lvl, tick);
endinterface : twi_line_if

// ---- twi_pin_sync.sv ----
// Three-stage synchroniser and agreement filter for the data and clock pins.
`timescale 1ns/100ps
module twi_pin_sync
	import twi_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	twi_line_if.filt  ln
);
	logic [1:0] raw;
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] s3_r;
	logic [1:0] lvl_r;
	logic [1:0] lvl_nxt;

	assign raw = {ln.scl_raw, ln.sda_raw};

	// A new level counts only once the second and third stages agree.
	for (genvar i = 0; i < 2; i++) begin : g_line
		always_comb begin
			lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : lvl_r[i];
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_r[i]  <= LINE_IDLE;
				s2_r[i]  <= LINE_IDLE;
				s3_r[i]  <= LINE_IDLE;
				lvl_r[i] <= LINE_IDLE;
			end else if (ce) begin
				s1_r[i]  <= raw[i];
				s2_r[i]  <= s1_r[i];
				s3_r[i]  <= s2_r[i];
				lvl_r[i] <= lvl_nxt[i];
			end
		end
	end

	assign ln.sda_lvl = lvl_r[0];
	assign ln.scl_lvl = lvl_r[1];

endmodule : twi_pin_sync

// ---- twi_rate_div.sv ----
// Half-period tick generator for the master serial clock.
`timescale 1ns/100ps
module twi_rate_div
	import twi_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	twi_line_if.div   ln
);
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;

	// A clear restarts the half period, so each sequencer state lasts a full one.
	always_comb begin
		cnt_nxt  = cnt_r - 10'h001;
		tick_nxt = 1'b0;
		if (ln.clr) begin
			cnt_nxt = half_of(ln.rate) - 10'h001; // [RULE10]
		end else if (cnt_r == 10'h000) begin
			tick_nxt = 1'b1;
			cnt_nxt  = half_of(ln.rate) - 10'h001; // [RULE10]
		end
	end

	// Counter registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= CNT_RST;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// A tick that meets a clear belongs to the old count, so it is withheld.
	assign ln.tick = tick_r && !ln.clr;

endmodule : twi_rate_div

// ---- twi_controller.sv ----
// Two-wire serial controller top: AHB-Lite registers, master clock sequencer and byte engine.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// [RULE1] Transport, clocking, address match and arbitration all run in hardware.
// [RULE2] Master or slave, transmitter or receiver, whole bytes at a time.
// [RULE3] Bus enable low releases both lines.
// [RULE4] Begin request makes START on a free bus, repeated START when held.
// [RULE5] Halt request makes STOP as master; a seen STOP clears it.
// [RULE6] Halt request acts at the next byte boundary, one interrupt later.
// [RULE7] Address flag set by hardware, cleared only by software.
// [RULE8] Ack enable drives data low in the acknowledge slot when receiving.
// [RULE9] Ack enable low leaves data released in the acknowledge slot.
// [RULE10] Master clock divisor 16,24,30,60,120,240,480,960 from three rate bits.
// [RULE11] Status register is read-only and usable as a service vector.
// [RULE12] Own address received with ack enable raises the interrupt flag.
// [RULE13] General call with call enable and ack enable raises the flag.
// [RULE14] Each master byte raises the flag, also when arbitration was lost; a loss in the address byte raises none unless addressed as slave.
// [RULE15] Each byte as addressed slave raises the flag.
// [RULE16] STOP seen while addressed slave raises the flag.
// [RULE17] Each line pin switches between port use and bus use.
// [RULE18] Incoming address compared with own address register in hardware.
// [RULE19] Reading status clears the interrupt flag.
// [RULE20] Software loads the seven-bit own address.
// [RULE21] Lost flag set on lost contention, cleared when a new start begins.
// [RULE22] Lines are only pulled low or released.
// [RULE23] After a loss the data line is released and the bus still watched.
module twi_controller
	import twi_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	input  wire logic        CE,
	// AHB-Lite slave.
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Data and clock pins.
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_N,
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE_N,
	// Interrupt request.
	output logic             IRQ
);
	twi_line_if ln();

	logic [7:0] ctrl_r, ctrl_nxt, own_r, own_nxt, port_r, port_nxt, shift_r, shift_nxt, dofs_r, dofs_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt;
	logic [9:0] gap_r, gap_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	m_state_t   m_r, m_nxt;
	logic irq_r, irq_nxt, stopf_r, stopf_nxt, gcf_r, gcf_nxt, lost_r, lost_nxt, nack_r, nack_nxt;
	logic tx_r, tx_nxt, master_r, master_nxt, addressed_r, addressed_nxt, busy_r, busy_nxt;
	logic addrph_r, addrph_nxt, match_r, match_nxt, gcall_r, gcall_nxt, boundary_r, boundary_nxt;
	logic sda_low_r, sda_low_nxt, scl_low_r, scl_low_nxt, sda_q_r, scl_q_r, clr_r, clr_nxt, dwr_r, dwr_nxt;
	logic sda_o_nxt, sda_oen_nxt, scl_o_nxt, scl_oen_nxt;
	logic aph, rd_stat, start_det, stop_det, scl_rise, lose, ack_give, irq_set;
	logic [7:0] byte_in, stat_val;

	// --------------------------------------------------------------------
	// Line filter and rate divider.
	// --------------------------------------------------------------------
	assign ln.sda_raw = SDA_I;
	assign ln.scl_raw = SCL_I;
	assign ln.rate    = {ctrl_r[CB_RATE2], ctrl_r[CB_RATE1], ctrl_r[CB_RATE0]}; // [RULE10]
	assign ln.clr     = clr_r;

	twi_pin_sync u_sync (.clk(CLK_SYS), .rst_n(RESETN), .ce(CE), .ln(ln));
	twi_rate_div u_div  (.clk(CLK_SYS), .rst_n(RESETN), .ce(CE), .ln(ln));

	// --------------------------------------------------------------------
	// Bus events and decodes.
	// --------------------------------------------------------------------
	// Events come from filtered levels only, so single-cycle glitches never reach the engine.
	assign start_det = ln.scl_lvl && scl_q_r && sda_q_r && !ln.sda_lvl;
	assign stop_det  = ln.scl_lvl && scl_q_r && !sda_q_r && ln.sda_lvl;
	assign scl_rise  = ln.scl_lvl && !scl_q_r;
	assign byte_in   = {shift_r[6:0], ln.sda_lvl};
	assign aph       = HSEL && HREADY && HTRANS[1];
	assign rd_stat   = aph && !HWRITE && (HADDR[7:0] == OFS_STAT);
	// A released one that reads back low means another master won.
	assign lose      = scl_rise && master_r && tx_r && !bitcnt_r[3] && shift_r[7] && !ln.sda_lvl; // [RULE1]
	// The receiver acknowledges its own address or a data byte when enabled.
	assign ack_give  = addrph_r ? (match_r && ctrl_r[CB_ACK] && !master_r)
	                            : (!tx_r && ctrl_r[CB_ACK] && (master_r || addressed_r)); // [RULE8]
	assign stat_val  = {gcf_r, stopf_r, irq_r, tx_r, busy_r && !master_r, lost_r, nack_r, addressed_r};

	// --------------------------------------------------------------------
	// Next-state logic for registers, sequencer and byte engine.
	// --------------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		own_nxt = own_r;
		port_nxt = port_r;
		shift_nxt = shift_r;
		bitcnt_nxt = bitcnt_r;
		m_nxt = m_r;
		irq_nxt = irq_r;
		stopf_nxt = stopf_r;
		gcf_nxt = gcf_r;
		lost_nxt = lost_r;
		nack_nxt = nack_r;
		tx_nxt = tx_r;
		master_nxt = master_r;
		addressed_nxt = addressed_r;
		busy_nxt = busy_r;
		addrph_nxt = addrph_r;
		match_nxt = match_r;
		gcall_nxt = gcall_r;
		boundary_nxt = boundary_r;
		sda_low_nxt = sda_low_r;
		irq_set = 1'b0;
		dwr_nxt = aph && HWRITE;
		dofs_nxt = aph ? HADDR[7:0] : dofs_r;
		hrdata_nxt = 32'h0000_0000;
		// Reads are answered from the address phase; status is read-only.
		if (aph && !HWRITE) begin
			case (HADDR[7:0])
				OFS_CTRL: hrdata_nxt[7:0] = ctrl_r;
				OFS_STAT: hrdata_nxt[7:0] = stat_val; // [RULE11]
				OFS_DATA: hrdata_nxt[7:0] = shift_r;
				OFS_OWN:  hrdata_nxt[7:0] = own_r;
				OFS_PORT: hrdata_nxt[7:0] = {ln.scl_lvl, ln.sda_lvl, port_r[5:0]};
				default:  hrdata_nxt = 32'h0000_0000;
			endcase
		end
		// Software writes land in the data phase.
		if (dwr_r) begin
			case (dofs_r)
				OFS_CTRL: ctrl_nxt = HWDATA[7:0]; // [RULE2]
				OFS_DATA: shift_nxt = HWDATA[7:0];
				OFS_OWN:  own_nxt = HWDATA[7:0]; // [RULE20]
				OFS_PORT: port_nxt = {2'b00, HWDATA[5:0]};
				default:  ;
			endcase
		end
		if (rd_stat) begin
			irq_nxt = 1'b0; // [RULE19]
			stopf_nxt = 1'b0;
		end
		if (!ctrl_r[CB_EN]) begin
			m_nxt = M_IDLE; // [RULE3]
			master_nxt = 1'b0;
			addressed_nxt = 1'b0;
			tx_nxt = 1'b0;
			addrph_nxt = 1'b0;
			busy_nxt = 1'b0;
			bitcnt_nxt = 4'h0;
			boundary_nxt = 1'b0;
			sda_low_nxt = 1'b0;
		end else begin
			// Master sequencer: every state but M_IDLE lasts at least one half period of the divider.
			case (m_r)
				M_IDLE: if (ctrl_r[CB_BEGIN] && !busy_r) begin
					m_nxt = M_START; // [RULE4]
					ctrl_nxt[CB_BEGIN] = 1'b0;
					master_nxt = 1'b1;
					lost_nxt = 1'b0; // [RULE21]
				end
				M_START: if (ln.tick) m_nxt = M_LOW;
				// At a byte boundary the clock is held low until the flag is read away.
				M_LOW: if (ln.tick && !(boundary_r && irq_r)) begin
					if (boundary_r && ctrl_r[CB_HALT]) m_nxt = M_STOP; // [RULE6]
					else if (boundary_r && ctrl_r[CB_BEGIN]) begin
						m_nxt = M_RS; // [RULE4]
						ctrl_nxt[CB_BEGIN] = 1'b0;
						lost_nxt = 1'b0;
					end else m_nxt = M_HIGH;
				end
				M_HIGH: if (ln.tick) m_nxt = M_LOW;
				M_RS: if (ln.tick) m_nxt = M_RS2;
				M_RS2: if (ln.tick) m_nxt = M_START;
				M_STOP: if (ln.tick) m_nxt = M_STOP2; // [RULE5]
				M_STOP2: if (ln.tick) begin
					m_nxt = M_IDLE;
					master_nxt = 1'b0;
				end
				default: m_nxt = M_IDLE;
			endcase
			// Byte engine: samples on every rising clock, whoever drives it.
			if (scl_rise && !bitcnt_r[3]) begin
				shift_nxt = byte_in;
				bitcnt_nxt = bitcnt_r + 4'h1;
				boundary_nxt = 1'b0;
				if (addrph_r && bitcnt_r == 4'h7) begin
					gcall_nxt = (byte_in == 8'h00) && own_r[OWN_GC];
					match_nxt = (byte_in[7:1] == own_r[7:1]) || gcall_nxt; // [RULE18]
				end
			end else if (scl_rise) begin
				bitcnt_nxt = 4'h0;
				boundary_nxt = 1'b1;
				nack_nxt = ln.sda_lvl;
				addrph_nxt = 1'b0;
				if (addrph_r && master_r) begin
					tx_nxt = !shift_r[0];
					irq_set = 1'b1; // [RULE14]
				end else if (addrph_r && match_r && ctrl_r[CB_ACK]) begin
					addressed_nxt = 1'b1;
					tx_nxt = shift_r[0] && !gcall_r;
					ctrl_nxt[CB_ADDR] = 1'b1; // [RULE7]
					gcf_nxt = gcall_r;
					irq_set = 1'b1; // [RULE12] [RULE13]
				end else if (!addrph_r && (master_r || addressed_r || lost_r)) begin
					irq_set = 1'b1; // [RULE14] [RULE15]
					if (addressed_r && tx_r && ln.sda_lvl) tx_nxt = 1'b0;
				end
			end
			if (lose) begin
				m_nxt = M_IDLE; // [RULE23]
				master_nxt = 1'b0;
				tx_nxt = 1'b0;
				lost_nxt = 1'b1; // [RULE21]
			end
			if (start_det) begin
				busy_nxt = 1'b1;
				addrph_nxt = 1'b1;
				bitcnt_nxt = 4'h0;
				boundary_nxt = 1'b0;
				addressed_nxt = 1'b0;
				match_nxt = 1'b0;
				tx_nxt = master_r;
			end
			if (stop_det) begin
				busy_nxt = 1'b0;
				addrph_nxt = 1'b0;
				bitcnt_nxt = 4'h0;
				tx_nxt = 1'b0;
				addressed_nxt = 1'b0;
				stopf_nxt = 1'b1;
				ctrl_nxt[CB_HALT] = 1'b0; // [RULE5]
				if (addressed_r) irq_set = 1'b1; // [RULE16]
			end
			// Data drive: sequencer conditions first, else change only while the clock is low.
			if (m_nxt == M_START || m_nxt == M_STOP || m_nxt == M_STOP2) sda_low_nxt = 1'b1;
			else if (m_nxt == M_RS || m_nxt == M_RS2) sda_low_nxt = 1'b0;
			else if (m_r == M_STOP2) sda_low_nxt = 1'b0; // [RULE5]
			else if (!ln.scl_lvl && !bitcnt_r[3]) sda_low_nxt = tx_nxt && !shift_r[7]; // [RULE23]
			else if (!ln.scl_lvl) sda_low_nxt = ack_give; // [RULE8] [RULE9]
		end
		// A new event wins over a clear in the same cycle.
		if (irq_set) irq_nxt = 1'b1;
	end

	// Clock drive, divider restart and pin multiplexer.
	always_comb begin
		scl_low_nxt = (m_nxt == M_LOW) || (m_nxt == M_RS) || (m_nxt == M_STOP)
		              || (addressed_r && boundary_r && irq_r && !ln.scl_lvl);
		// While the clock is released but held low by others, the high half waits.
		clr_nxt = (m_nxt != m_r) || (!scl_low_nxt && !ln.scl_lvl);
		gap_nxt = clr_r ? 10'h000 : (ln.tick ? 10'h001 : gap_r + 10'h001);
		sda_o_nxt = port_r[PB_SDA_BUS] ? 1'b0 : port_r[PB_SDA_OUT]; // [RULE22]
		scl_o_nxt = port_r[PB_SCL_BUS] ? 1'b0 : port_r[PB_SCL_OUT];
		sda_oen_nxt = port_r[PB_SDA_BUS] ? !(ctrl_r[CB_EN] && sda_low_r) : !port_r[PB_SDA_DRV]; // [RULE17] [RULE3]
		scl_oen_nxt = port_r[PB_SCL_BUS] ? !(ctrl_r[CB_EN] && scl_low_r) : !port_r[PB_SCL_DRV]; // [RULE17] [RULE3]
	end

	// --------------------------------------------------------------------
	// State registers.
	// --------------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_r <= CTRL_RST;
			own_r <= OWN_RST;
			port_r <= PORT_RST;
			shift_r <= 8'h00;
			dofs_r <= 8'h00;
			bitcnt_r <= 4'h0;
			gap_r <= CNT_RST;
			hrdata_r <= 32'h0000_0000;
			m_r <= M_IDLE;
			{irq_r, stopf_r, gcf_r, lost_r, nack_r, tx_r, master_r, addressed_r} <= 8'h00;
			{busy_r, addrph_r, match_r, gcall_r, boundary_r, sda_low_r, scl_low_r, dwr_r} <= 8'h00;
			{sda_q_r, scl_q_r, clr_r} <= 3'b111;
			{SDA_O, SDA_OE_N, SCL_O, SCL_OE_N} <= 4'b0101;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else if (CE) begin
			ctrl_r <= ctrl_nxt;
			own_r <= own_nxt;
			port_r <= port_nxt;
			shift_r <= shift_nxt;
			dofs_r <= dofs_nxt;
			bitcnt_r <= bitcnt_nxt;
			gap_r <= gap_nxt;
			hrdata_r <= hrdata_nxt;
			m_r <= m_nxt;
			{irq_r, stopf_r, gcf_r, lost_r, nack_r, tx_r, master_r, addressed_r} <=
				{irq_nxt, stopf_nxt, gcf_nxt, lost_nxt, nack_nxt, tx_nxt, master_nxt, addressed_nxt};
			{busy_r, addrph_r, match_r, gcall_r, boundary_r, sda_low_r, scl_low_r, dwr_r} <=
				{busy_nxt, addrph_nxt, match_nxt, gcall_nxt, boundary_nxt, sda_low_nxt, scl_low_nxt, dwr_nxt};
			{sda_q_r, scl_q_r, clr_r} <= {ln.sda_lvl, ln.scl_lvl, clr_nxt};
			{SDA_O, SDA_OE_N, SCL_O, SCL_OE_N} <= {sda_o_nxt, sda_oen_nxt, scl_o_nxt, scl_oen_nxt};
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	assign HRDATA = hrdata_r;
	assign IRQ    = irq_r;

	// --------------------------------------------------------------------
	// Assertions and covers.
	// --------------------------------------------------------------------
	default clocking dcb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	property p_off_release;
		CE && !ctrl_r[CB_EN] && port_r[PB_SDA_BUS] && port_r[PB_SCL_BUS] |=> SDA_OE_N && SCL_OE_N;
	endproperty
	a_off_release: assert property (p_off_release) else $error("Lines driven while disabled."); // [RULE3]
	property p_begin;
		CE && ctrl_r[CB_EN] && m_r == M_IDLE && ctrl_r[CB_BEGIN] && !busy_r |=> m_r == M_START ##1 sda_low_r;
	endproperty
	a_begin: assert property (p_begin) else $error("Begin request gave no START."); // [RULE4]
	property p_halt_clr;
		CE && ctrl_r[CB_EN] && stop_det |=> !ctrl_r[CB_HALT];
	endproperty
	a_halt_clr: assert property (p_halt_clr) else $error("Halt request kept after STOP."); // [RULE5]
	property p_addr_keep;
		CE && ctrl_r[CB_ADDR] && !(dwr_r && dofs_r == OFS_CTRL) |=> ctrl_r[CB_ADDR];
	endproperty
	a_addr_keep: assert property (p_addr_keep) else $error("Address flag cleared by hardware."); // [RULE7]
	property p_ack_low;
		CE && ctrl_r[CB_EN] && bitcnt_r == 4'h8 && ack_give && !ln.scl_lvl && m_r inside {M_IDLE, M_LOW, M_HIGH}
		|=> sda_low_r;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("Acknowledge not driven."); // [RULE8]
	property p_nack_rel;
		CE && ctrl_r[CB_EN] && bitcnt_r == 4'h8 && !ctrl_r[CB_ACK] && !tx_r && !ln.scl_lvl
		&& m_r inside {M_IDLE, M_LOW, M_HIGH} |=> !sda_low_r;
	endproperty
	a_nack_rel: assert property (p_nack_rel) else $error("Data driven with acknowledge off."); // [RULE9]
	property p_tick;
		ln.tick && m_r != M_IDLE |-> gap_r == half_of(ln.rate);
	endproperty
	a_tick: assert property (p_tick) else $error("Half period length wrong."); // [RULE10]
	property p_stat_clr;
		CE && rd_stat && !irq_set |=> !irq_r;
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("Status read left the flag set."); // [RULE19]
	property p_master_irq;
		CE && ctrl_r[CB_EN] && scl_rise && bitcnt_r == 4'h8 && master_r |=> irq_r;
	endproperty
	a_master_irq: assert property (p_master_irq) else $error("No flag after master byte."); // [RULE14]
	property p_stop_irq;
		CE && ctrl_r[CB_EN] && stop_det && addressed_r |=> irq_r && !addressed_r && stopf_r;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("No flag on STOP as slave."); // [RULE16]
	property p_loss;
		CE && ctrl_r[CB_EN] && lose && !start_det |=> !master_r && !tx_r && lost_r ##1 !sda_low_r;
	endproperty
	a_loss: assert property (p_loss) else $error("Data still driven after loss."); // [RULE23]

	c_start: cover property (m_r == M_START ##1 m_r == M_LOW);
	c_slave: cover property ($rose(addressed_r));
	c_loss:  cover property (lose);
	c_stop:  cover property (stop_det && addressed_r);

endmodule : twi_controller

// ---- twi_far_slave.sv ----
// Far-side bus slave model that acknowledges its own address byte only.
`timescale 1ns/100ps
module twi_far_slave #(
	parameter logic [6:0] ADDR7 = 7'h52
) (
	// Wire levels.
	input  wire logic scl,
	input  wire logic sda,
	// Data line drive, low while pulling the line down.
	output logic      sda_rel
);
	int         bitn = 9;
	logic [7:0] sh;
	initial sda_rel = 1'b1;
	// A start restarts the bit count; a stop ends the frame.
	always @(negedge sda) if (scl) bitn = 0;
	always @(posedge sda) if (scl) bitn = 9;
	// Bits are taken most significant first on the clock rise.
	always @(posedge scl) if (bitn < 8) begin
		sh = {sh[6:0], sda};
		bitn++;
	end
	// The acknowledge holds from one falling clock edge to the next, then the line goes back to its pull-up.
	always @(negedge scl) begin
		if (bitn == 8) begin
			sda_rel <= (sh[7:1] != ADDR7);
			bitn = 10;
		end else if (bitn == 10) begin
			sda_rel <= 1'b1;
			bitn = 9;
		end
	end
endmodule : twi_far_slave

// ---- test_twi_controller.sv ----
// Self-checking bench: registers, pin modes, master bytes at every rate and an aborted transfer.
`timescale 1ns/100ps
module test_twi_controller;
	import twi_pkg::*;
	// ----------
	// Signals.
	// ----------
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        sda_o, sda_oe_n, scl_o, scl_oe_n, irq, sda_rel;
	logic [31:0] rd;
	int          bad_count = 0;
	int          checks = 0;
	int          divs[8] = '{DIV_C0, DIV_C1, DIV_C2, DIV_C3, DIV_C4, DIV_C5, DIV_C6, DIV_C7};
	// Open-drain lines with pull-ups: a released driver shows the pull-up level.
	wire sda_line = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;
	wire scl_line = scl_oe_n ? 1'b1 : scl_o;
	twi_controller i_dut (.CLK_SYS(clk), .RESETN(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .SDA_I(sda_line), .SDA_O(sda_o),
		.SDA_OE_N(sda_oe_n), .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .IRQ(irq));
	twi_far_slave #(.ADDR7(7'h52)) i_far (.scl(scl_line), .sda(sda_line), .sda_rel(sda_rel));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------
	// Shared tasks.
	// ----------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// One AHB single word transfer; read data is taken at the end of the data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic conclude();
		if (bad_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	// ----------
	// Scenarios.
	// ----------
	task automatic t_regs();
		bus(1'b0, OFS_CTRL, 0);
		check("ctrl reset", rd, {24'h00_0000, CTRL_RST});
		bus(1'b1, OFS_OWN, 32'h0000_0036);
		bus(1'b0, OFS_OWN, 0);
		check("own address", rd, 32'h0000_0036);
		bus(1'b1, OFS_STAT, 32'h0000_00FF);
		bus(1'b0, OFS_STAT, 0);
		check("status", rd, 32'h0000_0000);
		bus(1'b1, 8'h20, 32'h0000_FFFF);
		bus(1'b0, 8'h20, 0);
		check("unmapped", rd, 32'h0000_0000);
	endtask : t_regs
	// Port mode drives the data pin low; the filtered levels read back.
	task automatic t_port();
		bus(1'b1, OFS_PORT, 32'h0000_0010);
		repeat (8) @(posedge clk);
		check("port drive", {sda_oe_n, sda_o, scl_oe_n}, 3'b001);
		bus(1'b0, OFS_PORT, 0);
		check("port levels", rd[7:6], 2'b10);
		bus(1'b1, OFS_PORT, 32'h0000_0003);
	endtask : t_port
	// Address byte as master, then halt before the status read; odd codes get no acknowledge.
	task automatic t_byte(input logic [2:0] code, input logic [7:0] ab);
		int  n;
		time t0;
		bus(1'b1, OFS_DATA, {24'h00_0000, ab});
		bus(1'b1, OFS_CTRL, {24'h00_0000, code[2], 5'b11000, code[1:0]});
		@(posedge scl_line);
		t0 = $time;
		@(posedge scl_line);
		n = int'(($time - t0) / 25);
		check("clock period", 32'(n >= divs[code] && n <= divs[code] + 12), 32'h0000_0001);
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		check("irq", irq, 1'b1);
		bus(1'b1, OFS_CTRL, {24'h00_0000, code[2], 5'b10100, code[1:0]});
		bus(1'b0, OFS_STAT, 0);
		check("status", rd[5:0], {4'b1100, ab[7:1] != 7'h52, 1'b0});
		repeat (2) @(posedge clk);
		check("irq cleared", irq, 1'b0);
		n = 0;
		do begin
			bus(1'b0, OFS_CTRL, 0);
			n++;
		end while (rd[4] !== 1'b0 && n < 3000);
		check("halt cleared", rd[4], 1'b0);
		check("lines idle", {sda_line, scl_line}, 2'b11);
		repeat (40) @(posedge clk);
	endtask : t_byte
	// Disabling in mid-byte releases both lines.
	task automatic t_abort();
		bus(1'b1, OFS_DATA, 32'h0000_00A4);
		bus(1'b1, OFS_CTRL, 32'h0000_0063);
		@(posedge scl_line);
		@(posedge scl_line);
		bus(1'b1, OFS_CTRL, 0);
		repeat (8) @(posedge clk);
		check("released", {sda_oe_n, scl_oe_n}, 2'b11);
	endtask : t_abort
	// ----------
	// Main sequence and watchdog.
	// ----------
	initial begin
		rst_n  = 1'b0;
		hsel   = 1'b0;
		haddr  = 0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_port();
		for (int k = 0; k < 8; k++) t_byte(3'(k), k[0] ? 8'hA6 : 8'hA4);
		t_abort();
		conclude();
	end
	// Every rate once costs about a dozen serial periods each; this span leaves ample margin.
	initial begin
		#(25 * 90000);
		bad_count++;
		conclude();
	end
endmodule : test_twi_controller
